/* design/pwr_pkg.sv */
// package: constants and types for the power, reset and wake control block
// Function
// [RULE_01] counter array 0033, keyboard 003b, serial 0043
// [RULE_02] two priority bits give level zero to three
// [RULE_03] pre-empt only by strictly higher level
// [RULE_04] higher level wins simultaneous requests
// [RULE_05] equal levels resolved by fixed polling
// [RULE_06] lowest source index wins within level
// [RULE_07] reset held at least 24 oscillator periods
// [RULE_08] watchdog timeout drives 96 clock reset pulse
// [RULE_09] boot map enable loaded from fuse at reset
// [RULE_10] idle bit write is last instruction
// [RULE_11] idle gates core clock, peripherals keep running
// [RULE_12] idle holds state, strobes driven high
// [RULE_13] enabled interrupt clears idle bit, serviced
// [RULE_14] two general flags kept across idle
// [RULE_15] hardware reset also ends idle mode
// [RULE_16] power-down bit stops the oscillator
// [RULE_17] state retained throughout power-down
// [RULE_18] power-down exit only reset or enabled wakes
// [RULE_19] keyboard wake waits 1024 clocks
// [RULE_20] low input restarts oscillator, high completes exit
// [RULE_21] both enabled: first release completes exit
// [RULE_22] wake applied only after supply restored
// [RULE_23] idle and power-down together enter power-down
package pwr_pkg;
    localparam int NUM_SRC = 8;                  // interrupt sources
    localparam int POWER_CONTROL_REGISTER_IDLE_BIT = 0;            // idle bit position
    localparam int POWER_CONTROL_REGISTER_PD_BIT = 1;              // power-down bit position
    localparam int POWER_CONTROL_REGISTER_GFA_BIT = 2;             // general flag a position
    localparam int POWER_CONTROL_REGISTER_GFB_BIT = 3;             // general flag b position
    localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;   // power control reset value
    localparam logic [15:0] VEC_COUNTER_ARRAY = 16'h0033;
    localparam logic [15:0] VEC_KEYBOARD = 16'h003b;
    localparam logic [15:0] VEC_SERIAL = 16'h0043;
    // standard core vectors: ext a, timer0, ext b, timer1, uart, timer2
    localparam logic [15:0] VEC_EXT_A = 16'h0003;
    localparam logic [15:0] VEC_TIMER0 = 16'h000b;
    localparam logic [15:0] VEC_EXT_B = 16'h0013;
    localparam logic [15:0] VEC_TIMER1 = 16'h001b;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TIMER2 = 16'h002b;
    localparam int SRC_EXT_A = 0;
    localparam int SRC_EXT_B = 2;
    localparam int SRC_KEYBOARD = 7;
    localparam int WDT_PULSE_CYCLES = 96;        // reset-out pulse length
    localparam int KBD_WAKE_CYCLES = 1024;       // keyboard wake delay
    localparam int RESET_MIN_CYCLES = 24;        // least reset hold by source
    typedef enum {ST_RUN, ST_IDLE, ST_PD, ST_PD_WAKE, ST_KBD_WAIT} mode_type;
endpackage

/* design/irq_if.sv */
// interface: request and arbitration result between top and arbiter
`timescale 1ns/10ps
interface irq_if #(parameter int N = 8);
    logic [N-1:0] req;          // pending and enabled requests
    logic [N-1:0] prio_high;    // high priority bits
    logic [N-1:0] prio_low;     // low priority bits
    logic [2:0] active_level;   // 0 none, else running level + 1
    logic grant;                // a request may be taken now
    logic [$clog2(N)-1:0] win;  // winning source
    logic [1:0] win_level;      // level of the winner
    modport top (output req, prio_high, prio_low, active_level,
                 input grant, win, win_level);
    modport arb (input req, prio_high, prio_low, active_level,
                 output grant, win, win_level);
endinterface

/* design/irq_arbiter.sv */
// combinational priority arbiter with fixed polling inside each level
`timescale 1ns/10ps
module irq_arbiter #(
    parameter int N = 8
) (
    irq_if.arb bus
);
    logic [1:0] lvl;
    // scan from high index down so the lowest index is left winning
    always_comb begin
        bus.grant = 1'b0;
        bus.win = '0;
        bus.win_level = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            lvl = {bus.prio_high[i], bus.prio_low[i]};                // RULE_02
            // a tie goes to the lower index, later in the scan
            if (bus.req[i] && (!bus.grant || lvl >= bus.win_level)) begin // RULE_05
                bus.grant = 1'b1;
                bus.win = ($clog2(N))'(i);                            // RULE_06
                bus.win_level = lvl;                                  // RULE_04
            end
        end
        // only a strictly higher level may pre-empt the running service
        if (bus.grant && ({1'b0, bus.win_level} + 3'h1) <= bus.active_level) begin
            bus.grant = 1'b0;                                         // RULE_03
        end
    end
endmodule

/* design/power_reset_wake_control.sv */
// top: power modes, wake arbitration, vectors, watchdog reset pulse, boot map
`timescale 1ns/10ps
module power_reset_wake_control #(
    parameter int NUM_SRC = pwr_pkg::NUM_SRC,
    parameter int KBD_WAKE = pwr_pkg::KBD_WAKE_CYCLES,
    parameter int WDT_PULSE = pwr_pkg::WDT_PULSE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [NUM_SRC-1:0] irq_req_i,          // raw requests, pins
    input wire logic [NUM_SRC-1:0] irq_enable_i,       // source enables
    input wire logic [NUM_SRC-1:0] priority_high_bits_i,
    input wire logic [NUM_SRC-1:0] priority_low_bits_i,
    input wire logic power_control_register_write_i,                     // core writes power control
    input wire logic [7:0] power_control_register_wdata_i,
    input wire logic irq_ack_i,                        // core took the vector
    input wire logic return_from_interrupt_i,          // core ends service
    input wire logic watchdog_timeout_i,               // one-cycle timeout
    input wire logic boot_jump_fuse_i,                 // fuse level
    output logic [7:0] power_control_register_o,
    output logic core_clk_en_o,                        // core clock gate
    output logic osc_run_o,                            // oscillator enable
    output logic addr_latch_strobe_o,
    output logic program_store_strobe_o,
    output logic hold_state_o,                         // freeze core and ports
    output logic irq_valid_o,
    output logic [15:0] irq_vector_o,
    output logic [1:0] irq_level_o,
    output logic reset_out_o,                          // drive reset pin
    output logic reset_out_oe_o,
    output logic boot_map_enable_o
);
    localparam int SW = $clog2(NUM_SRC);
    localparam int KW = $clog2(KBD_WAKE + 1);
    localparam int WW = $clog2(WDT_PULSE + 1);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        pwr_pkg::mode_type mode;
        logic [7:0] power_control_register;
        logic [NUM_SRC-1:0] s1;
        logic [NUM_SRC-1:0] s2;
        logic [KW-1:0] kcnt;
        logic [WW-1:0] wcnt;
        logic [8:0] lvl_stack;       // running levels + 1, three deep, 0 is none
        logic [1:0] ext_prev;        // external pins one cycle after sync
        logic valid;
        logic [15:0] vector;
        logic [1:0] level;
        logic boot;
        logic boot_loaded;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic [NUM_SRC-1:0] pend;        // synchronised and enabled requests
    logic wake_ext_low;              // an external pin held low
    logic [2:0] lvl_p1;
    logic ext_release;               // an enabled external pin just went high

    irq_if #(.N(NUM_SRC)) arb_bus ();

    irq_arbiter #(.N(NUM_SRC)) u_arb (
        .bus(arb_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // vector map
    function automatic logic [15:0] vector_of(input logic [SW-1:0] s);
        case (s)
            3'd0: vector_of = pwr_pkg::VEC_EXT_A;
            3'd1: vector_of = pwr_pkg::VEC_TIMER0;
            3'd2: vector_of = pwr_pkg::VEC_EXT_B;
            3'd3: vector_of = pwr_pkg::VEC_TIMER1;
            3'd4: vector_of = pwr_pkg::VEC_UART;
            3'd5: vector_of = pwr_pkg::VEC_COUNTER_ARRAY;   // RULE_01
            3'd6: vector_of = pwr_pkg::VEC_SERIAL;          // RULE_01
            default: vector_of = pwr_pkg::VEC_KEYBOARD;     // RULE_01
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // arbiter inputs
    assign pend = st_q.s2 & irq_enable_i;
    assign arb_bus.req = st_q.valid ? '0 : pend;
    assign arb_bus.prio_high = priority_high_bits_i;
    assign arb_bus.prio_low = priority_low_bits_i;
    assign arb_bus.active_level = st_q.lvl_stack[2:0];
    // with both pins low, the first one released ends the exit
    assign ext_release = (irq_enable_i[pwr_pkg::SRC_EXT_A] && st_q.s2[pwr_pkg::SRC_EXT_A]
        && !st_q.ext_prev[0])
        || (irq_enable_i[pwr_pkg::SRC_EXT_B] && st_q.s2[pwr_pkg::SRC_EXT_B]
        && !st_q.ext_prev[1]);
    assign wake_ext_low = (irq_enable_i[pwr_pkg::SRC_EXT_A] && !st_q.s2[pwr_pkg::SRC_EXT_A])
        || (irq_enable_i[pwr_pkg::SRC_EXT_B] && !st_q.s2[pwr_pkg::SRC_EXT_B]);

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        lvl_p1 = 3'h0;
        st_d.ext_prev = {st_q.s2[pwr_pkg::SRC_EXT_B], st_q.s2[pwr_pkg::SRC_EXT_A]};
        // external pins pass two flops before use
        st_d.s1 = irq_req_i;
        st_d.s2 = st_q.s1;
        // boot map taken from the fuse once, right after reset release
        if (!st_q.boot_loaded) begin
            st_d.boot = boot_jump_fuse_i;                           // RULE_09
            st_d.boot_loaded = 1'b1;
        end
        // watchdog reset-out pulse; a new timeout restarts it
        if (watchdog_timeout_i) begin
            st_d.wcnt = WW'(WDT_PULSE);                             // RULE_08
        end else if (st_q.wcnt != '0) begin
            st_d.wcnt = st_q.wcnt - WW'(1);
        end
        // core acknowledges vector; push running level
        if (irq_ack_i && st_q.valid) begin
            st_d.valid = 1'b0;
            lvl_p1 = {1'b0, st_q.level} + 3'h1;
            st_d.lvl_stack = {st_q.lvl_stack[5:0], lvl_p1};
        end else if (return_from_interrupt_i) begin
            st_d.lvl_stack = {3'h0, st_q.lvl_stack[8:3]};
        end
        case (st_q.mode)
            pwr_pkg::ST_RUN: begin
                if (arb_bus.grant) begin
                    st_d.valid = 1'b1;
                    st_d.vector = vector_of(arb_bus.win);
                    st_d.level = arb_bus.win_level;
                end
                if (power_control_register_write_i) begin
                    st_d.power_control_register = power_control_register_wdata_i;                       // RULE_14
                    if (power_control_register_wdata_i[pwr_pkg::POWER_CONTROL_REGISTER_PD_BIT]) begin
                        st_d.mode = pwr_pkg::ST_PD;                 // RULE_23
                    end else if (power_control_register_wdata_i[pwr_pkg::POWER_CONTROL_REGISTER_IDLE_BIT]) begin
                        st_d.mode = pwr_pkg::ST_IDLE;               // RULE_10
                    end
                end
            end
            pwr_pkg::ST_IDLE: begin
                // an enabled request granted by the arbiter, above any running level, clears idle and is serviced
                if (arb_bus.grant) begin
                    st_d.power_control_register[pwr_pkg::POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;       // RULE_13
                    st_d.valid = 1'b1;
                    st_d.vector = vector_of(arb_bus.win);
                    st_d.level = arb_bus.win_level;
                    st_d.mode = pwr_pkg::ST_RUN;
                end
            end
            pwr_pkg::ST_PD: begin
                // only the two external pins and the keyboard wake
                if (wake_ext_low) begin
                    st_d.mode = pwr_pkg::ST_PD_WAKE;                // RULE_20
                end else if (pend[pwr_pkg::SRC_KEYBOARD]) begin
                    st_d.mode = pwr_pkg::ST_KBD_WAIT;               // RULE_18
                    st_d.kcnt = KW'(KBD_WAKE);
                end
            end
            pwr_pkg::ST_PD_WAKE: begin
                // oscillator runs; first release of a low pin ends exit
                if (!wake_ext_low || ext_release) begin
                    st_d.power_control_register[pwr_pkg::POWER_CONTROL_REGISTER_PD_BIT] = 1'b0;         // RULE_21
                    st_d.mode = pwr_pkg::ST_RUN;
                end
            end
            default: begin
                if (st_q.kcnt <= KW'(1)) begin
                    st_d.power_control_register[pwr_pkg::POWER_CONTROL_REGISTER_PD_BIT] = 1'b0;         // RULE_19
                    st_d.mode = pwr_pkg::ST_RUN;
                end else begin
                    st_d.kcnt = st_q.kcnt - KW'(1);
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; hardware reset ends any mode and clears the flags
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q.mode <= pwr_pkg::ST_RUN;                           // RULE_15
            st_q.power_control_register <= pwr_pkg::POWER_CONTROL_REGISTER_RESET;
            st_q.s1 <= '1;
            st_q.s2 <= '1;
            st_q.kcnt <= '0;
            st_q.wcnt <= '0;
            st_q.lvl_stack <= '0;
            st_q.ext_prev <= 2'h3;
            st_q.valid <= 1'b0;
            st_q.vector <= 16'h0000;
            st_q.level <= 2'h0;
            st_q.boot <= 1'b0;
            st_q.boot_loaded <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each from a flop of its own
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_clk_en_o <= 1'b1;
            osc_run_o <= 1'b1;
            hold_state_o <= 1'b0;
            addr_latch_strobe_o <= 1'b1;
            program_store_strobe_o <= 1'b1;
            reset_out_o <= 1'b0;
            reset_out_oe_o <= 1'b0;
        end else begin
            // core clock gated in idle and power-down
            core_clk_en_o <= (st_d.mode == pwr_pkg::ST_RUN);        // RULE_11
            // oscillator off while waiting in power-down
            osc_run_o <= (st_d.mode != pwr_pkg::ST_PD);             // RULE_16
            hold_state_o <= (st_d.mode != pwr_pkg::ST_RUN);         // RULE_17
            addr_latch_strobe_o <= 1'b1;                            // RULE_12
            program_store_strobe_o <= 1'b1;                         // RULE_12
            reset_out_o <= (st_d.wcnt != '0);                       // RULE_08
            reset_out_oe_o <= (st_d.wcnt != '0);
        end
    end

    assign power_control_register_o = st_q.power_control_register;
    assign irq_valid_o = st_q.valid;
    assign irq_vector_o = st_q.vector;
    assign irq_level_o = st_q.level;
    assign boot_map_enable_o = st_q.boot;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_pd_over_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_23
        (st_q.mode == pwr_pkg::ST_RUN && power_control_register_write_i && power_control_register_wdata_i[1])
        |=> st_q.mode == pwr_pkg::ST_PD) else $error("power-down not taken");
    a_idle_gates_clk: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_11
        st_q.mode == pwr_pkg::ST_IDLE |-> !core_clk_en_o && osc_run_o)
        else $error("idle clock gating wrong");
    a_pd_stops_osc: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_16
        st_q.mode == pwr_pkg::ST_PD |-> !osc_run_o) else $error("oscillator runs in power-down");
    a_wdt_pulse_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_08
        $rose(reset_out_o) |-> reset_out_o [*8]) else $error("reset pulse too short");
    a_idle_wake_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_13
        (st_q.mode == pwr_pkg::ST_IDLE && arb_bus.grant)
        |=> !st_q.power_control_register[0] && irq_valid_o) else $error("idle wake not serviced");
    a_strobes_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_12
        hold_state_o |-> addr_latch_strobe_o && program_store_strobe_o)
        else $error("strobes low in idle");
    a_kbd_wait_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_19
        (st_q.mode == pwr_pkg::ST_KBD_WAIT && st_q.kcnt > 10'd1)
        |=> st_q.mode == pwr_pkg::ST_KBD_WAIT) else $error("keyboard wake too early");
    a_no_preempt_top: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE_03
        st_q.lvl_stack[2:0] == 3'h4 |-> !arb_bus.grant) else $error("top level pre-empted");
    c_idle_wake: cover property (@(posedge sys_clk_i) st_q.mode == pwr_pkg::ST_IDLE ##1
        st_q.mode == pwr_pkg::ST_RUN);
    c_pd_ext_wake: cover property (@(posedge sys_clk_i) st_q.mode == pwr_pkg::ST_PD_WAKE);
    c_kbd_wake: cover property (@(posedge sys_clk_i) st_q.mode == pwr_pkg::ST_KBD_WAIT);
    c_wdt_pulse: cover property (@(posedge sys_clk_i) $rose(reset_out_o));
endmodule

/* dv/core_partner.sv */
// core-side model: takes each offered vector and later ends its service
`timescale 1ns/10ps
module core_partner (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic irq_valid_i,   // vector offered by the block
    input wire logic slow_i,        // answer late instead of at once
    input wire logic hold_i,        // keep running services open
    output logic irq_ack_o,         // pulse: vector taken
    output logic ret_o              // pulse: service ended
);
    int wait_q;     // cycles the offered vector has waited
    int depth_q;    // services taken and not yet ended
    // a gap follows every pulse so ack and return never merge into a level
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_ack_o <= 1'b0;
            ret_o <= 1'b0;
            wait_q <= 0;
            depth_q <= 0;
        end else if (irq_ack_o || ret_o) begin
            irq_ack_o <= 1'b0;
            ret_o <= 1'b0;
        end else if (irq_valid_i) begin
            wait_q <= wait_q + 1;
            if (wait_q >= (slow_i ? 5 : 0)) begin
                irq_ack_o <= 1'b1;
                depth_q <= depth_q + 1;
                wait_q <= 0;
            end
        end else if (depth_q > 0 && !hold_i) begin
            ret_o <= 1'b1;          // a return only ever follows its ack
            depth_q <= depth_q - 1;
        end
    end
endmodule

/* dv/tb_power_reset_wake_control.sv */
// testbench: random and corner stimulus for the power, reset and wake block
`timescale 1ns/10ps
module tb_power_reset_wake_control;
    localparam int KBD = 8;   // short keyboard wake keeps the run brief
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] req = 8'h05;  // pin sources idle high
    logic [7:0] en = 8'h00;
    logic [7:0] ph = 8'h00;
    logic [7:0] pl = 8'h00;
    logic pw = 1'b0;
    logic [7:0] pd = 8'h00;
    logic wd = 1'b0;
    logic fuse = 1'b1;
    logic slow = 1'b0;
    logic hold = 1'b0;
    logic ack, ret, clk_en, osc, ale, pss, hold_st, valid, rst_o, rst_oe, boot;
    logic [7:0] power_control_register;
    logic [15:0] vec;
    logic [1:0] lvl;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32;
    always #50 sys_clk_i = ~sys_clk_i;
    power_reset_wake_control #(.KBD_WAKE(KBD), .WDT_PULSE(96)) dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .irq_req_i(req),
        .irq_enable_i(en), .priority_high_bits_i(ph), .priority_low_bits_i(pl),
        .power_control_register_write_i(pw), .power_control_register_wdata_i(pd), .irq_ack_i(ack),
        .return_from_interrupt_i(ret), .watchdog_timeout_i(wd),
        .boot_jump_fuse_i(fuse), .power_control_register_o(power_control_register),
        .core_clk_en_o(clk_en), .osc_run_o(osc), .addr_latch_strobe_o(ale),
        .program_store_strobe_o(pss), .hold_state_o(hold_st), .irq_valid_o(valid),
        .irq_vector_o(vec), .irq_level_o(lvl), .reset_out_o(rst_o),
        .reset_out_oe_o(rst_oe), .boot_map_enable_o(boot));
    core_partner u_core (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .irq_valid_i(valid), .slow_i(slow), .hold_i(hold), .irq_ack_o(ack), .ret_o(ret));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // bounded wait for an offered vector, sampled mid-cycle
    task automatic wait_valid(input int lim, output bit got);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(negedge sys_clk_i);
            got = (valid === 1'b1);
        end
    endtask
    // quiet for 8 cycles: stray pending requests are drained by the partner
    task automatic settle();
        int q;
        q = 0;
        for (int i = 0; i < 300 && q < 8; i++) begin
            @(negedge sys_clk_i);
            q = (valid === 1'b0 && u_core.depth_q == 0 && !ack && !ret) ? q + 1 : 0;
        end
        @(posedge sys_clk_i);
    endtask
    task automatic power_control_register_wr(input logic [7:0] d);
        @(posedge sys_clk_i);
        pw <= 1'b1;
        pd <= d;
        @(posedge sys_clk_i);
        pw <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic do_reset(input logic f);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        fuse <= f;
        cyc(24);
        chk("power_control_register_rst", 16'h0000, {8'h00, power_control_register});
        chk_bit("clk_rst", 1'b1, clk_en);
        chk_bit("osc_rst", 1'b1, osc);
        chk_bit("rstout_rst", 1'b0, rst_o);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_bit("boot_map", f, boot);
        cyc(3);
    endtask
    // winner: highest level, lowest index among equals
    function automatic int winner(logic [7:0] m, logic [7:0] h, logic [7:0] l);
        int b;
        b = -1;
        for (int i = 0; i < 8; i++) begin
            if (m[i] && (b < 0 || {h[i], l[i]} > {h[b], l[b]})) b = i;
        end
        return b;
    endfunction
    function automatic logic [15:0] vec_of(int i);
        case (i)
            0: return pwr_pkg::VEC_EXT_A;
            1: return pwr_pkg::VEC_TIMER0;
            2: return pwr_pkg::VEC_EXT_B;
            3: return pwr_pkg::VEC_TIMER1;
            4: return pwr_pkg::VEC_UART;
            5: return pwr_pkg::VEC_COUNTER_ARRAY;
            6: return pwr_pkg::VEC_SERIAL;
            default: return pwr_pkg::VEC_KEYBOARD;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        error_cnt++;
        test_done();
    end
    initial begin
        int srcs[6] = '{1, 3, 4, 5, 6, 7};
        logic [7:0] m, h, l;
        logic [1:0] t;
        bit got;
        int n, w;
        cyc(4);
        reset_n_i <= 1'b1;
        do_reset(1'b1);
        do_reset(1'b0);
        // single sources first, then full ties, then random contention
        for (int k = 0; k < 24; k++) begin
            m = 8'($random(seed)) & 8'hfa;
            h = 8'($random(seed));
            l = 8'($random(seed));
            if (k < 6) m = 8'h01 << srcs[k];
            if (k == 6) {m, h, l} = {8'hfa, 8'h00, 8'h00};
            if (k == 7) {m, h, l} = {8'hfa, 8'hff, 8'hff};
            if (m == 8'h00) m = 8'h08;
            w = winner(m, h, l);
            slow <= k[0];
            en <= 8'hfa;
            ph <= h;
            pl <= l;
            req <= m | 8'h05;
            wait_valid(20, got);
            chk_bit("valid", 1'b1, got);
            chk("vector", vec_of(w), vec);
            chk("level", {14'h0, h[w], l[w]}, {14'h0, lvl});
            @(posedge sys_clk_i);
            req <= 8'h05;
            settle();
        end
        // a running service at each level against equal and higher requests
        slow <= 1'b0;
        en <= 8'h0a;
        for (int v = 0; v < 4; v++) begin
            t = 2'(v);
            hold <= 1'b1;
            ph <= t[1] ? 8'h0a : 8'h00;
            pl <= t[0] ? 8'h0a : 8'h00;
            req <= 8'h07;
            wait_valid(20, got);
            @(posedge sys_clk_i);
            req <= 8'h05;
            cyc(4);
            req <= 8'h0d;
            wait_valid(12, got);
            chk_bit("preempt_eq", 1'b0, got);
            if (v < 3) begin
                t = 2'(v + 1);
                @(posedge sys_clk_i);
                ph[3] <= t[1];
                pl[3] <= t[0];
                wait_valid(12, got);
                chk_bit("preempt_hi", 1'b1, got);
                chk("vector_hi", pwr_pkg::VEC_TIMER1, vec);
            end
            @(posedge sys_clk_i);
            req <= 8'h05;
            hold <= 1'b0;
            settle();
        end
        // watchdog reset pulse length on the pin
        wd <= 1'b1;
        @(posedge sys_clk_i);
        wd <= 1'b0;
        n = 0;
        for (int i = 0; i < 300 && !(n > 0 && rst_o !== 1'b1); i++) begin
            @(negedge sys_clk_i);
            if (rst_o === 1'b1 && rst_oe === 1'b1) n++;
        end
        chk("wdt_pulse", 16'd96, 16'(n));
        // idle with both flags, woken by an enabled request
        en <= 8'h10;
        power_control_register_wr(8'h0d);
        chk("power_control_register_idle", 16'h000d, {8'h00, power_control_register});
        chk_bit("clk_idle", 1'b0, clk_en);
        chk_bit("osc_idle", 1'b1, osc);
        chk("strobes", 16'h0003, {14'h0, ale, pss});
        chk_bit("hold_idle", 1'b1, hold_st);
        @(posedge sys_clk_i);
        req <= 8'h15;
        wait_valid(20, got);
        chk("power_control_register_wake", 16'h000c, {8'h00, power_control_register});
        chk_bit("clk_wake", 1'b1, clk_en);
        chk("vec_wake", pwr_pkg::VEC_UART, vec);
        @(posedge sys_clk_i);
        req <= 8'h05;
        settle();
        power_control_register_wr(8'h01);
        do_reset(1'b1);
        // power-down: one pin, then both pins with the other one released first
        for (int v = 0; v < 2; v++) begin
            en <= 8'h07;
            power_control_register_wr(v ? 8'h03 : 8'h02);
            chk_bit("osc_pd", 1'b0, osc);
            chk_bit("clk_pd", 1'b0, clk_en);
            chk_bit("pd_bit", 1'b1, power_control_register[1]);
            @(posedge sys_clk_i);
            req <= 8'h07;
            cyc(10);
            chk_bit("osc_nowake", 1'b0, osc);
            req <= v ? 8'h02 : 8'h06;
            cyc(6);
            chk_bit("osc_restart", 1'b1, osc);
            chk_bit("clk_hold", 1'b0, clk_en);
            req <= v ? 8'h06 : 8'h07;
            cyc(6);
            chk_bit("clk_exit", 1'b1, clk_en);
            chk_bit("pd_clear", 1'b0, power_control_register[1]);
            en <= 8'h00;
            req <= 8'h05;
            settle();
        end
        // keyboard wake must sit out its delay before the core clock returns
        en <= 8'h80;
        power_control_register_wr(8'h02);
        @(posedge sys_clk_i);
        req <= 8'h85;
        n = 0;
        for (int i = 0; i < 200 && clk_en !== 1'b1; i++) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_bit("kbd_exit", 1'b1, clk_en);
        chk_bit("kbd_delay", 1'b1, n >= KBD && n <= KBD + 8);
        @(posedge sys_clk_i);
        req <= 8'h05;
        en <= 8'h00;
        settle();
        test_done();
    end
endmodule
